/* File: hw/switch_line_resync_control.sv */
// Switch-line resync control for word aligner and timing generator
// Notes on behaviour
// R1: Sample the switch-resync request every pixel clock cycle.
// R2: Rising edge in active line triggers resync at next timing reference word.
// R3: Only rising edges trigger; a steady high level does nothing more.
// R4: Controller raises request in active line, holds about one line, then lowers.
// R5: Automatic resync once per field or frame at the standard switch line.
// R6: 525 lines: end of lines 10 and 273 interlaced, line 10 progressive.
// R7: 625 lines: end of lines 6 and 319 interlaced, line 6 progressive.
// R8: 750 lines progressive: end of line 7.
// R9: 1125 lines: end of lines 7 and 568 interlaced, line 7 progressive.
// R10: 1125 PsF at 25/30 treated interlaced unless payload says progressive; 24 PsF known.
// R11: Level B to A with extended active: resync at next TRS if phase <= 10 us.
// R12: Phase above 10 us: resync takes one extra line.
// R13: Phase limit applies only with conversion on and extended active period.
// R14: Operates only in full video-processing mode.
// R15: Needs one frame to sync, then realigns counters on every TRS.
// R16: Edge from current versus previous sample, qualified by active line.
`timescale 1ns/1ns
module switch_line_resync_control
    import switch_resync_pkg::*;
#(
    parameter int PHASE_LIMIT = PHASE_LIMIT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic switch_resync_request_i,
    input wire logic smpte_mode_i,
    input wire logic level_b_to_a_i,
    input wire logic input_3g_i,
    input wire logic extended_active_i,
    input wire logic [PHASE_W-1:0] phase_diff_cyc_i,
    input wire video_std_s std_i,
    input wire timing_s timing_i,
    output logic resync_o,
    output logic realign_o,
    output logic resync_pending_o,
    output logic extra_line_o
);

    typedef enum logic [1:0] {
        IDLE,
        ARMED,
        WAIT_LINE
    } resync_state_e;

    // Request pin is asynchronous to the pixel clock
    logic req_meta;
    logic req_sync;
    logic req_prev;
    logic next_req_meta;
    logic next_req_sync;
    logic next_req_prev;

    resync_state_e state;
    resync_state_e next_state;
    logic resync;
    logic next_resync;
    logic realign;
    logic next_realign;
    logic extra_line;
    logic next_extra_line;

    logic req_rise;
    logic auto_hit;
    logic is_interlaced;
    logic limit_applies;
    logic phase_ok;
    logic enabled;
    logic pending;
    logic next_pending;

    localparam int N_STRUCT = 2 ** $bits(line_struct_e);
    logic [10:0] first_line [N_STRUCT];
    logic [10:0] second_line [N_STRUCT];
    logic [N_STRUCT-1:0] has_second;
    logic [N_STRUCT-1:0] struct_hit;

    always_comb begin
        next_req_meta = switch_resync_request_i; // R1
        next_req_sync = req_meta;
        next_req_prev = req_sync;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
            req_prev <= 1'b0;
        end else begin
            req_meta <= next_req_meta;
            req_sync <= next_req_sync;
            req_prev <= next_req_prev;
        end
    end

    // Bypass and pass-through modes have no timing generator
    assign enabled = smpte_mode_i; // R14

    // Edge only; a held level never retriggers
    assign req_rise = req_sync && !req_prev && timing_i.active_line; // R16 R3 R2

    // 25/30 PsF cannot be told from interlace without payload ID
    always_comb begin
        is_interlaced = std_i.interlaced; // R10
        if (std_i.lines == LINES_1125 && std_i.psf) begin
            is_interlaced = !std_i.rate_24 && !std_i.payload_prog; // R10
        end
    end

    // Switch-line table, one entry per line structure
    always_comb begin
        first_line[LINES_525] = SW_LINE_525_F1; // R6
        second_line[LINES_525] = SW_LINE_525_F2; // R6
        has_second[LINES_525] = 1'b1;
        first_line[LINES_625] = SW_LINE_625_F1; // R7
        second_line[LINES_625] = SW_LINE_625_F2; // R7
        has_second[LINES_625] = 1'b1;
        first_line[LINES_750] = SW_LINE_750; // R8
        second_line[LINES_750] = SW_LINE_750;
        // Progressive only, so no second field line
        has_second[LINES_750] = 1'b0;
        first_line[LINES_1125] = SW_LINE_1125_F1; // R9
        second_line[LINES_1125] = SW_LINE_1125_F2; // R9
        has_second[LINES_1125] = 1'b1;
    end

    for (genvar k = 0; k < N_STRUCT; k++) begin : g_switch_line
        assign struct_hit[k] = (std_i.lines == line_struct_e'(k)) &&
            ((timing_i.line_num == first_line[k]) ||
            (has_second[k] && is_interlaced && timing_i.line_num == second_line[k]));
    end

    // Line numbers mean nothing until the counters have seen a frame
    assign auto_hit = timing_i.eol && timing_i.frame_synced && (struct_hit != '0); // R5 R15

    assign limit_applies = input_3g_i && level_b_to_a_i && extended_active_i; // R13
    assign phase_ok = (32'(phase_diff_cyc_i) <= PHASE_LIMIT); // R11

    always_comb begin
        next_state = state;
        next_resync = 1'b0;
        next_extra_line = extra_line;
        // Counters follow every TRS once the first frame has locked
        next_realign = enabled && timing_i.trs_id && timing_i.frame_synced; // R15
        if (!enabled) begin
            next_state = IDLE;
            next_extra_line = 1'b0;
        end else begin
            case (state)
                IDLE: begin
                    if (req_rise || auto_hit) begin // R2 R5
                        if (limit_applies && !phase_ok) begin
                            next_state = WAIT_LINE; // R12
                            next_extra_line = 1'b1;
                        end else begin
                            next_state = ARMED;
                        end
                    end
                end
                ARMED: begin
                    if (timing_i.trs_id) begin
                        next_resync = 1'b1; // R2 R11
                        next_state = IDLE;
                    end
                end
                WAIT_LINE: begin
                    // Let one reference pass; H pulse may be missing on that line
                    if (timing_i.trs_id) begin
                        next_state = ARMED; // R12
                        next_extra_line = 1'b0;
                    end
                end
                default: begin
                    next_state = IDLE;
                end
            endcase
        end
        next_pending = (next_state != IDLE);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= IDLE;
            resync <= 1'b0;
            realign <= 1'b0;
            extra_line <= 1'b0;
            pending <= 1'b0;
        end else begin
            state <= next_state;
            pending <= next_pending;
            resync <= next_resync;
            realign <= next_realign;
            extra_line <= next_extra_line;
        end
    end

    // Own flop so the output never glitches on a state decode
    assign resync_pending_o = pending;
    assign resync_o = resync;
    assign realign_o = realign;
    assign extra_line_o = extra_line;

endmodule

/* File: hw/switch_resync_pkg.sv */
// Package for switch-line resync control: constants and carrier types
package switch_resync_pkg;

    // Line structures
    typedef enum logic [1:0] {
        LINES_525,
        LINES_625,
        LINES_750,
        LINES_1125
    } line_struct_e;

    // Switch lines per structure (second value for second interlaced field)
    localparam logic [10:0] SW_LINE_525_F1 = 11'h00A;
    localparam logic [10:0] SW_LINE_525_F2 = 11'h111;
    localparam logic [10:0] SW_LINE_625_F1 = 11'h006;
    localparam logic [10:0] SW_LINE_625_F2 = 11'h13F;
    localparam logic [10:0] SW_LINE_750 = 11'h007;
    localparam logic [10:0] SW_LINE_1125_F1 = 11'h007;
    localparam logic [10:0] SW_LINE_1125_F2 = 11'h238;

    // Phase limit for Level B to A conversion
    localparam int PHASE_LIMIT_NS = 10000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int PHASE_LIMIT_CYC = PHASE_LIMIT_NS / CLK_PERIOD_NS;
    localparam int PHASE_W = 16;

    // Video standard as reported by the standard detector
    typedef struct packed {
        line_struct_e lines;
        logic interlaced;
        logic psf;
        logic rate_24;
        logic payload_prog;
    } video_std_s;

    // Timing status from the timing counters
    typedef struct packed {
        logic [10:0] line_num;
        logic active_line;
        logic eol;
        logic trs_id;
        logic frame_synced;
    } timing_s;

endpackage

/* File: dv/switch_line_resync_control_chk.sv */
// Port checker for switch-line resync control
`timescale 1ns/1ns
module switch_line_resync_control_chk
    import switch_resync_pkg::*;
#(parameter int PHASE_LIMIT = PHASE_LIMIT_CYC) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic switch_resync_request_i,
    input wire logic smpte_mode_i,
    input wire logic level_b_to_a_i,
    input wire logic input_3g_i,
    input wire logic extended_active_i,
    input wire logic [PHASE_W-1:0] phase_diff_cyc_i,
    input wire video_std_s std_i,
    input wire timing_s timing_i,
    input wire logic resync_o,
    input wire logic realign_o,
    input wire logic resync_pending_o,
    input wire logic extra_line_o
);
    logic [2:0] hi_age;
    logic [10:0] f1, f2;
    logic two, big;
    // Saturates so a held pin cannot wrap back into the edge window
    always_ff @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i) hi_age <= 3'h0;
        else hi_age <= !switch_resync_request_i ? 3'h0 : hi_age + {2'h0, hi_age != 3'h7};
    always_comb
        case (std_i.lines)
            LINES_525: {f1, f2} = {SW_LINE_525_F1, SW_LINE_525_F2};
            LINES_625: {f1, f2} = {SW_LINE_625_F1, SW_LINE_625_F2};
            LINES_750: {f1, f2} = {SW_LINE_750, 11'h7FF};
            default: {f1, f2} = {SW_LINE_1125_F1, SW_LINE_1125_F2};
        endcase
    assign two = (std_i.lines == LINES_1125 && std_i.psf) ?
        (!std_i.rate_24 && !std_i.payload_prog) : std_i.interlaced;
    assign big = level_b_to_a_i && input_3g_i && extended_active_i && phase_diff_cyc_i > PHASE_LIMIT;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    auto_first_a: assert property (smpte_mode_i && timing_i.frame_synced && !resync_pending_o && timing_i.eol && timing_i.line_num == f1 |=> resync_pending_o) else $error("first switch line missed");
    auto_second_a: assert property (smpte_mode_i && timing_i.frame_synced && !resync_pending_o && timing_i.eol && two && timing_i.line_num == f2 |=> resync_pending_o) else $error("second switch line missed");
    resync_cause_a: assert property (resync_o |-> $past(timing_i.trs_id) && $past(resync_pending_o) && !resync_pending_o) else $error("resync without armed reference");
    resync_next_a: assert property (resync_pending_o && !extra_line_o && timing_i.trs_id && smpte_mode_i && !big |=> resync_o) else $error("resync late");
    mode_off_a: assert property (!smpte_mode_i && !$past(smpte_mode_i) |-> !resync_pending_o && !resync_o) else $error("active outside full mode");
    realign_a: assert property (timing_i.trs_id && timing_i.frame_synced && smpte_mode_i |=> realign_o) else $error("realign missed");
    extra_cond_a: assert property ($rose(extra_line_o) |-> $past(big)) else $error("extra line without cause");
    edge_only_a: assert property ($rose(resync_pending_o) && !$past(timing_i.eol) |-> hi_age inside {[3'h1:3'h6]}) else $error("arm without fresh edge");
    cover property ($rose(extra_line_o));
    cover property (resync_o);
    cover property (realign_o);
endmodule
bind switch_line_resync_control switch_line_resync_control_chk #(.PHASE_LIMIT(PHASE_LIMIT)) chk_i (.*);

/* File: dv/resync_ctrl_model.sv */
// Controller model driving the switch-resync request pin
`timescale 1ns/1ns
module resync_ctrl_model #(parameter int HOLD = 40) (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic stuck_i,
    input wire logic active_i,
    output logic req_o
);
    int n = 0;
    initial req_o = 1'b0;
    // Raise in active video, hold about a line, then drop
    always @(negedge clk_i) begin
        if (go_i && !req_o && active_i) begin
            req_o <= 1'b1;
            n <= HOLD;
        end else if (n != 0) begin
            n <= n - 1;
        end else if (!stuck_i) begin
            req_o <= 1'b0;
        end
    end
endmodule

/* File: dv/switch_line_resync_control_test.sv */
// Testbench for switch-line resync control
`timescale 1ns/1ns
module switch_line_resync_control_test
    import switch_resync_pkg::*;
;
    logic clk_i, rst_n_i, switch_resync_request_i, smpte_mode_i, level_b_to_a_i, input_3g_i;
    logic extended_active_i, resync_o, realign_o, resync_pending_o, extra_line_o, go, stuck;
    logic [PHASE_W-1:0] phase_diff_cyc_i;
    video_std_s std_i;
    timing_s timing_i;
    int pos = 0, err_count = 0, n_checks = 0;
    logic [31:0] n_rs = 32'h0000_0000, n_ex = 32'h0000_0000, n_ra = 32'h0000_0000;
    switch_line_resync_control #(.PHASE_LIMIT(20)) switch_line_resync_control_i (.*);
    resync_ctrl_model resync_ctrl_model_i (.clk_i(clk_i), .go_i(go), .stuck_i(stuck),
        .active_i(timing_i.active_line), .req_o(switch_resync_request_i));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Short 40-cycle lines keep the run brief
    always @(negedge clk_i) begin
        pos <= pos == 39 ? 0 : pos + 1;
        timing_i.trs_id <= pos == 39;
        timing_i.eol <= pos == 38;
        timing_i.active_line <= pos inside {[8:30]};
        if (pos == 39) timing_i.line_num <= timing_i.line_num + 11'h001;
    end
    always @(posedge clk_i) begin
        n_rs += resync_o;
        n_ex += extra_line_o;
        n_ra += realign_o;
    end
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic lines(int n);
        repeat (n * 40) @(negedge clk_i);
    endtask
    task automatic press();
        do @(negedge clk_i); while (pos != 6);
        go = 1'b1;
        for (int i = 0; i < 80 && !switch_resync_request_i; i++) @(negedge clk_i);
        go = 1'b0;
    endtask
    task automatic au(line_struct_e l, logic [3:0] f, logic [10:0] ln, int e);
        do @(negedge clk_i); while (pos != 5);
        std_i = '{l, f[3], f[2], f[1], f[0]};
        timing_i.line_num = ln;
        n_rs = 0;
        lines(2);
        chk(n_rs, e);
        $display("auto line %0d done", ln);
    endtask
    task automatic t_man(logic m, int e);
        smpte_mode_i = m;
        {n_rs, n_ra} = {32'h0000_0000, 32'h0000_0000};
        press();
        lines(3);
        chk(n_rs, e);
        chk(32'(n_ra != 0), 32'(m));
        smpte_mode_i = 1'b1;
        $display("manual test done");
    endtask
    task automatic t_held();
        stuck = 1'b1;
        n_rs = 0;
        press();
        lines(4);
        chk(n_rs, 1);
        stuck = 1'b0;
        lines(2);
        $display("held test done");
    endtask
    task automatic t_phase(logic c, logic [PHASE_W-1:0] p, int e);
        {level_b_to_a_i, input_3g_i, extended_active_i, phase_diff_cyc_i} = {c, 2'h3, p};
        {n_rs, n_ex} = {32'h0000_0000, 32'h0000_0000};
        press();
        lines(4);
        chk(n_rs, 1);
        chk(int'(n_ex != 0), e);
        $display("phase test done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // About 80 lines of traffic; allow three times that
    initial begin
        #100000;
        err_count++;
        end_of_test();
    end
    initial begin
        {rst_n_i, go, stuck, smpte_mode_i, level_b_to_a_i, input_3g_i, extended_active_i} = 7'h08;
        phase_diff_cyc_i = 16'h0000;
        std_i = '{LINES_1125, 1'b0, 1'b0, 1'b0, 1'b0};
        timing_i = '{11'h064, 1'b0, 1'b0, 1'b0, 1'b1};
        repeat (6) @(negedge clk_i);
        rst_n_i = 1'b1;
        lines(1);
        au(LINES_525, 4'h8, 11'h00A, 1);
        au(LINES_525, 4'h8, 11'h111, 1);
        au(LINES_525, 4'h0, 11'h111, 0);
        au(LINES_625, 4'h8, 11'h006, 1);
        au(LINES_625, 4'h8, 11'h13F, 1);
        au(LINES_625, 4'h0, 11'h006, 1);
        au(LINES_750, 4'h0, 11'h007, 1);
        au(LINES_1125, 4'h8, 11'h238, 1);
        au(LINES_1125, 4'h8, 11'h239, 0);
        au(LINES_1125, 4'h0, 11'h007, 1);
        au(LINES_1125, 4'h4, 11'h238, 1);
        au(LINES_1125, 4'h6, 11'h238, 0);
        au(LINES_1125, 4'h5, 11'h238, 0);
        t_man(1'b1, 1);
        t_man(1'b1, 1);
        t_man(1'b0, 0);
        t_held();
        t_phase(1'b1, 16'h0014, 0);
        t_phase(1'b1, 16'h0015, 1);
        t_phase(1'b0, 16'h0015, 0);
        end_of_test();
    end
endmodule
